/* File: rtl/sbst_tap.v */
`timescale 1ns/10ps
`default_nettype none
`include "sbst_map.vh"

module sbst_tap #(
	parameter                 PIN_W   = 16,
	parameter                 HOLD_W  = 2,
	parameter [`SBST_ID_W-1:0] ID_WORD = 32'h0000_0001 // arbitrary value
) (
	input  wire               mclk_in,
	input  wire               rst_in,
	input  wire               tck_in,
	input  wire               tms_in,
	input  wire               tdi_in,
	input  wire               tms_drv_in,
	input  wire               tdi_drv_in,
	input  wire [PIN_W-1:0]   pins_in,
	output reg                tdo_out,
	output reg                tdo_oe_n_out,
	output reg                sram_hiz_out,
	output reg                extest_out,
	output reg  [PIN_W-1:0]   bscan_out,
	output reg  [3:0]         tap_state_out
);
	localparam BSR_W = PIN_W + HOLD_W;

	// two-stage synchronisers; first stage read only by second
	reg                  tck_s1_r;
	reg                  tck_s2_r;
	reg                  tck_d_r;
	reg                  tms_s1_r;
	reg                  tms_s2_r;
	reg                  tdi_s1_r;
	reg                  tdi_s2_r;
	reg [PIN_W-1:0]      pins_s1_r;
	reg [PIN_W-1:0]      pins_s2_r;

	reg [3:0]            st_r;
	reg [3:0]            st_nxt;
	reg [3:0]            st_go;
	reg [`SBST_IR_W-1:0] ir_sh_r;
	reg [`SBST_IR_W-1:0] ir_r;
	reg                  byp_r;
	reg [BSR_W-1:0]      bsr_r;
	reg [`SBST_ID_W-1:0] id_r;
	reg [2:0]            tms_cnt_r;
	reg                  tdo_nxt;

	wire                 tck_v;
	wire                 tms_v;
	wire                 tdi_v;
	wire                 rise;
	wire                 fall;
	wire                 in_sh_dr;
	wire                 in_sh_ir;
	wire                 tms_flush;

	assign tck_v     = tck_s2_r;
	assign tms_v     = tms_s2_r;
	assign tdi_v     = tdi_s2_r;
	assign rise      = tck_v & ~tck_d_r;
	assign fall      = ~tck_v & tck_d_r;
	assign in_sh_dr  = (st_r == `SBST_S_SH_DR);
	assign in_sh_ir  = (st_r == `SBST_S_SH_IR);
	assign tms_flush = tms_v && (tms_cnt_r >= `SBST_RESET_LAST);

	function bsr_sel;
		input [`SBST_IR_W-1:0] code;
		begin
			bsr_sel = (code == `SBST_IR_EXTEST) ||
				(code == `SBST_IR_FLOAT) ||
				(code == `SBST_IR_SAMPLE);
		end
	endfunction

	function id_sel;
		input [`SBST_IR_W-1:0] code;
		begin
			id_sel = (code == `SBST_IR_IDREAD);
		end
	endfunction

	// tck rests low in reset; a high-resting clock then costs one rise,
	// harmless since reset state holds while mode select reads high
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tck_s1_r <= 1'b0;
			tck_s2_r <= 1'b0;
			tck_d_r  <= 1'b0;
		end else begin
			tck_s1_r <= tck_in;
			tck_s2_r <= tck_s1_r;
			tck_d_r  <= tck_s2_r;
		end
	end

	// undriven inputs read as one, like an internal pull-up
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tms_s1_r <= 1'b1;
			tms_s2_r <= 1'b1;
		end else begin
			tms_s1_r <= tms_in | ~tms_drv_in;
			tms_s2_r <= tms_s1_r;
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tdi_s1_r <= 1'b1;
			tdi_s2_r <= 1'b1;
		end else begin
			tdi_s1_r <= tdi_in | ~tdi_drv_in;
			tdi_s2_r <= tdi_s1_r;
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pins_s1_r <= {PIN_W{1'b0}};
			pins_s2_r <= {PIN_W{1'b0}};
		end else begin
			pins_s1_r <= pins_in;
			pins_s2_r <= pins_s1_r;
		end
	end

	always @* begin
		case (st_r)
		`SBST_S_RESET: begin
			st_nxt = tms_v ? `SBST_S_RESET : `SBST_S_IDLE;
		end
		`SBST_S_IDLE: begin
			st_nxt = tms_v ? `SBST_S_SEL_DR : `SBST_S_IDLE;
		end
		`SBST_S_SEL_DR: begin
			st_nxt = tms_v ? `SBST_S_SEL_IR : `SBST_S_CAP_DR;
		end
		`SBST_S_CAP_DR: begin
			st_nxt = tms_v ? `SBST_S_EX1_DR : `SBST_S_SH_DR;
		end
		`SBST_S_SH_DR: begin
			st_nxt = tms_v ? `SBST_S_EX1_DR : `SBST_S_SH_DR;
		end
		`SBST_S_EX1_DR: begin
			st_nxt = tms_v ? `SBST_S_UPD_DR : `SBST_S_PAU_DR;
		end
		`SBST_S_PAU_DR: begin
			st_nxt = tms_v ? `SBST_S_EX2_DR : `SBST_S_PAU_DR;
		end
		`SBST_S_EX2_DR: begin
			st_nxt = tms_v ? `SBST_S_UPD_DR : `SBST_S_SH_DR;
		end
		`SBST_S_UPD_DR: begin
			st_nxt = tms_v ? `SBST_S_SEL_DR : `SBST_S_IDLE;
		end
		`SBST_S_SEL_IR: begin
			st_nxt = tms_v ? `SBST_S_RESET : `SBST_S_CAP_IR;
		end
		`SBST_S_CAP_IR: begin
			st_nxt = tms_v ? `SBST_S_EX1_IR : `SBST_S_SH_IR;
		end
		`SBST_S_SH_IR: begin
			st_nxt = tms_v ? `SBST_S_EX1_IR : `SBST_S_SH_IR;
		end
		`SBST_S_EX1_IR: begin
			st_nxt = tms_v ? `SBST_S_UPD_IR : `SBST_S_PAU_IR;
		end
		`SBST_S_PAU_IR: begin
			st_nxt = tms_v ? `SBST_S_EX2_IR : `SBST_S_PAU_IR;
		end
		`SBST_S_EX2_IR: begin
			st_nxt = tms_v ? `SBST_S_UPD_IR : `SBST_S_SH_IR;
		end
		`SBST_S_UPD_IR: begin
			st_nxt = tms_v ? `SBST_S_SEL_DR : `SBST_S_IDLE;
		end
		default: begin
			st_nxt = `SBST_S_RESET;
		end
		endcase
	end

	always @* begin
		if (tms_flush)
			st_go = `SBST_S_RESET;
		else
			st_go = st_nxt;
	end

	// belt-and-braces path; the state graph alone reaches reset within
	// five high samples, the counter also covers a corrupted state code
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tms_cnt_r <= 3'h0;
		end else if (rise) begin
			if (!tms_v)
				tms_cnt_r <= 3'h0;
			else if (tms_cnt_r != 3'h7)
				tms_cnt_r <= tms_cnt_r + 3'h1;
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= `SBST_S_RESET;
		end else if (rise) begin                 // no tck edge, no change
			st_r <= st_go;
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ir_sh_r <= `SBST_IR_IDREAD;
			ir_r    <= `SBST_IR_IDREAD;
		end else if (rise) begin
			if (st_go == `SBST_S_RESET) begin
				// forced on the way in, so no stale instruction acts there
				ir_sh_r <= `SBST_IR_IDREAD;
				ir_r    <= `SBST_IR_IDREAD;
			end else begin
				case (st_r)
				`SBST_S_CAP_IR: begin
					ir_sh_r <= {ir_sh_r[`SBST_IR_W-1], `SBST_IR_CAPTURE};
				end
				`SBST_S_SH_IR: begin
					ir_sh_r <= {tdi_v, ir_sh_r[`SBST_IR_W-1:1]};
				end
				`SBST_S_UPD_IR: begin
					ir_r <= ir_sh_r;
				end
				default: begin
				end
				endcase
			end
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			byp_r <= 1'b0;
		end else if (rise) begin
			if (st_r == `SBST_S_CAP_DR)
				byp_r <= 1'b0;
			else if (in_sh_dr && !id_sel(ir_r) && !bsr_sel(ir_r))
				byp_r <= tdi_v;
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			id_r <= {`SBST_ID_W{1'b0}};
		end else if (rise) begin
			if (st_r == `SBST_S_CAP_DR && id_sel(ir_r))
				id_r <= ID_WORD;
			else if (in_sh_dr && id_sel(ir_r))
				id_r <= {tdi_v, id_r[`SBST_ID_W-1:1]};
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			bsr_r <= {BSR_W{1'b1}};
		end else if (rise) begin
			if (st_r == `SBST_S_CAP_DR && bsr_sel(ir_r))
				bsr_r <= {{HOLD_W{1'b1}}, pins_s2_r};
			else if (in_sh_dr && bsr_sel(ir_r))
				bsr_r <= {tdi_v, bsr_r[BSR_W-1:1]};
		end
	end

	always @* begin
		tdo_nxt = byp_r;
		if (in_sh_ir)
			tdo_nxt = ir_sh_r[0];
		else if (id_sel(ir_r))
			tdo_nxt = id_r[0];
		else if (bsr_sel(ir_r))
			tdo_nxt = bsr_r[0];
	end

	// falling-edge outputs
	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tdo_out <= 1'b1;
		end else if (fall) begin
			tdo_out <= tdo_nxt;
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tdo_oe_n_out <= 1'b1;
		end else if (fall) begin
			tdo_oe_n_out <= ~(in_sh_dr || in_sh_ir);
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tap_state_out <= `SBST_S_RESET;
		end else if (fall) begin
			tap_state_out <= st_r;
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sram_hiz_out <= 1'b0;
			extest_out   <= 1'b0;
		end else if (fall) begin
			sram_hiz_out <= (ir_r == `SBST_IR_FLOAT);
			extest_out   <= (ir_r == `SBST_IR_EXTEST);
		end
	end

	always @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			bscan_out <= {PIN_W{1'b0}};
		end else if (fall && (st_r == `SBST_S_UPD_DR ||
				st_r == `SBST_S_UPD_IR)) begin
			bscan_out <= bsr_r[PIN_W-1:0];
		end
	end
endmodule
`default_nettype wire

/* File: shared/sbst_map.vh */
`ifndef SBST_MAP_VH
`define SBST_MAP_VH

`define SBST_IR_W        3
`define SBST_ID_W        32
`define SBST_IR_EXTEST   3'h0
`define SBST_IR_IDREAD   3'h1
`define SBST_IR_FLOAT    3'h2
`define SBST_IR_RFU_A    3'h3
`define SBST_IR_SAMPLE   3'h4
`define SBST_IR_PRIVATE  3'h5
`define SBST_IR_RFU_B    3'h6
`define SBST_IR_BYPASS   3'h7
`define SBST_IR_CAPTURE  2'h1
`define SBST_RESET_TMS   5
`define SBST_RESET_LAST  3'h4

`define SBST_S_RESET     4'h0
`define SBST_S_IDLE      4'h1
`define SBST_S_SEL_DR    4'h2
`define SBST_S_CAP_DR    4'h3
`define SBST_S_SH_DR     4'h4
`define SBST_S_EX1_DR    4'h5
`define SBST_S_PAU_DR    4'h6
`define SBST_S_EX2_DR    4'h7
`define SBST_S_UPD_DR    4'h8
`define SBST_S_SEL_IR    4'h9
`define SBST_S_CAP_IR    4'hA
`define SBST_S_SH_IR     4'hB
`define SBST_S_EX1_IR    4'hC
`define SBST_S_PAU_IR    4'hD
`define SBST_S_EX2_IR    4'hE
`define SBST_S_UPD_IR    4'hF

`endif

/* File: sim/sbst_tap_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sbst_map.vh"
module sbst_tap_chk (
	input wire logic       mclk_in,
	input wire logic       rst_in,
	input wire logic       tck_in,
	input wire logic       tms_in,
	input wire logic       tms_drv_in,
	input wire logic       tdo_out,
	input wire logic       tdo_oe_n_out,
	input wire logic       sram_hiz_out,
	input wire logic       extest_out,
	input wire logic [3:0] tap_state_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	logic       tck_r;
	logic [2:0] ones_r;
	wire        rise = tck_in & !tck_r;
	wire        tms1 = tms_in | !tms_drv_in;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			tck_r  <= 1'b0;
			ones_r <= 3'h0;
		end else begin
			tck_r <= tck_in;
			if (rise)
				ones_r <= tms1 ? ones_r + 3'h1 : 3'h0;
		end
	end
	property p_oe_shift;
		!tdo_oe_n_out |-> tap_state_out == `SBST_S_SH_DR ||
			tap_state_out == `SBST_S_SH_IR;
	endproperty
	a_oe_shift: assert property (p_oe_shift) else $error("tdo on");
	property p_tdo_fall;
		!$stable(tdo_out) |-> !tck_in;
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo edge");
	property p_st_fall;
		!$stable(tap_state_out) |-> !tck_in;
	endproperty
	a_st_fall: assert property (p_st_fall) else $error("state edge");
	property p_rst5;
		rise && tms1 && ones_r == 3'h4 |-> ##[1:12]
			tap_state_out == `SBST_S_RESET;
	endproperty
	a_rst5: assert property (p_rst5) else $error("no tms reset");
	property p_quiet;
		$stable(tck_in) [*8] |-> $stable(tap_state_out);
	endproperty
	a_quiet: assert property (p_quiet) else $error("moved idle");
	property p_oe_on;
		$past(tap_state_out) == `SBST_S_SH_DR &&
			tap_state_out == `SBST_S_SH_DR |-> !tdo_oe_n_out;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("tdo off");
	property p_tlr_ir;
		tap_state_out == `SBST_S_RESET && $past(tap_state_out) ==
			`SBST_S_RESET |-> !sram_hiz_out && !extest_out;
	endproperty
	a_tlr_ir: assert property (p_tlr_ir) else $error("reset instr");
	property p_tlr_exit;
		$past(tap_state_out) == `SBST_S_RESET && !$stable(tap_state_out)
			|-> tap_state_out == `SBST_S_IDLE;
	endproperty
	a_tlr_exit: assert property (p_tlr_exit) else $error("bad exit");
	c_shift: cover property (!tdo_oe_n_out);
	c_hiz: cover property (sram_hiz_out);
	c_ext: cover property (extest_out);
endmodule
bind sbst_tap sbst_tap_chk i_chk (.mclk_in, .rst_in, .tck_in, .tms_in,
	.tms_drv_in, .tdo_out, .tdo_oe_n_out, .sram_hiz_out, .extest_out,
	.tap_state_out);
`default_nettype wire

/* File: sim/sbst_tap_host.sv */
`timescale 1ns/10ps
`default_nettype none
module sbst_tap_host (
	input  wire logic mclk_in,
	input  wire logic tdo_in,
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	output logic      tms_drv_out,
	output logic      tdi_drv_out
);
	// loose: lines left open, so drive the inverse of the meant level
	logic loose = 1'b0;
	assign tms_drv_out = !loose;
	assign tdi_drv_out = !loose;
	// tck rests low between calls
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b1;
	end
	task step(input logic m, input logic d, output logic q);
		tms_out = loose ? !m : m;
		tdi_out = loose ? !d : d;
		repeat (6) @(negedge mclk_in);
		q = tdo_in;
		tck_out = 1'b1;
		repeat (2) @(negedge mclk_in);
		tck_out = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: sim/sbst_tap_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "sbst_map.vh"
module sbst_tap_tb;
	localparam [31:0] ID = 32'h5A3C_0F91; // arbitrary value
	localparam [15:0] PINS = 16'hA5C3;
	localparam [33:0] V = 34'h2_3C96_A5E1;
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        tck, tms, tdi, tms_d, tdi_d, tdo, oe_n, hiz, ext, b;
	logic [15:0] bsc;
	logic [3:0]  st;
	logic [33:0] q;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cyc = 0;
	sbst_tap #(.ID_WORD(ID)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
		.tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tms_drv_in(tms_d),
		.tdi_drv_in(tdi_d), .pins_in(PINS), .tdo_out(tdo),
		.tdo_oe_n_out(oe_n), .sram_hiz_out(hiz), .extest_out(ext),
		.bscan_out(bsc), .tap_state_out(st));
	sbst_tap_host i_host (.mclk_in(mclk_in), .tdo_in(tdo), .tck_out(tck),
		.tms_out(tms), .tdi_out(tdi), .tms_drv_out(tms_d),
		.tdi_drv_out(tdi_d));
	task automatic chk(input string nm, input logic [33:0] e, g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// outputs follow a tck fall by about three clocks of sync latency
	task automatic settle;
		repeat (4) @(negedge mclk_in);
	endtask
	task automatic scan(input logic ir, input int n, input logic [33:0] v);
		i_host.step(1'b1, 1'b1, b);
		if (ir)
			i_host.step(1'b1, 1'b1, b);
		i_host.step(1'b0, 1'b1, b);
		i_host.step(1'b0, 1'b1, b);
		q = '0;
		for (int i = 0; i < n; i++) begin
			i_host.step(i == n - 1, v[i], b);
			q[i] = b;
		end
		i_host.step(1'b1, 1'b1, b);
		i_host.step(1'b0, 1'b1, b);
		settle;
	endtask
	task automatic test_done;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		forever #20 mclk_in = !mclk_in;
	end
	// far above the few thousand cycles the sequence needs
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done;
		end
	end
	initial begin
		repeat (12) @(negedge mclk_in);
		rst_in = 1'b0;
		repeat (5) i_host.step(1'b1, 1'b1, b);
		i_host.step(1'b0, 1'b1, b);
		settle;
		chk("state", `SBST_S_IDLE, st);
		scan(1'b0, 32, V);
		chk("id", ID, q);
		for (int c = 0; c < 8; c++) begin
			scan(1'b1, 3, c);
			chk("ir capture", 2'h1, q[1:0]);
			chk("float", c == 2, hiz);
			chk("extest", c == 0, ext);
			scan(1'b0, 34, V);
			if (c == 1)
				chk("id", ID, q[31:0]);
			else if (c == 0 || c == 2 || c == 4) begin
				chk("bsr", {2'h3, PINS}, q[17:0]);
				chk("bscan", V[31:16], bsc);
			end else
				chk("bypass", V[32:0], q[33:1]);
		end
		scan(1'b1, 3, `SBST_IR_FLOAT);
		chk("float set", 1'b1, hiz);
		repeat (5) i_host.step(1'b1, 1'b1, b);
		settle;
		chk("reset float", 1'b0, hiz);
		i_host.step(1'b0, 1'b1, b);
		scan(1'b0, 32, V);
		chk("reset id", ID, q);
		i_host.loose = 1'b1;
		repeat (5) i_host.step(1'b1, 1'b1, b);
		settle;
		chk("open tms", `SBST_S_RESET, st);
		repeat (100) @(negedge mclk_in);
		chk("still", `SBST_S_RESET, st);
		test_done;
	end
endmodule
`default_nettype wire
